// file: rtl/siplat_regs.svh
// Purpose: Constants for the serial-in, parallel-out latch.
// Assumes: Included by bare name; definitions only.
// Notes: Host pins arrive synchronous to core_clk.
//
// What this block does
// - Eight-stage shifter feeding eight-bit storage outputs
// - Shift clock rise advances shifter one stage
// - Data enters stage 0; others take lower
// - Storage clock rise copies all shifter stages
// - Parallel outputs change only on transfer, clear
// - Shared clock: storage trails shifter one pulse
// - Each low clear empties only its register
// - Clears act directly; clocks are independent
// - Serial output allows chaining further devices
`ifndef SIPLAT_REGS_SVH
`define SIPLAT_REGS_SVH

// Register width and reset content
`define SIPLAT_WIDTH 8
`define SIPLAT_CLEAR_VAL 8'h00
// Stage that takes the serial input
`define SIPLAT_STAGE_IN 0
// Idle level of the edge history after reset
`define SIPLAT_EDGE_RST 1'h1

`endif

// file: rtl/siplat_pkg.sv
// Purpose: Types for the serial-in, parallel-out latch.
// Assumes: Width fixed by the header constant.
// Notes: Host pin group travels as one struct.
`include "siplat_regs.svh"

package siplat_pkg;

  // Register contents
  typedef logic [`SIPLAT_WIDTH-1:0] siplat_data_t;

  // Pins driven by the host controller
  typedef struct packed {
    logic serial_data_in;
    logic shift_clock;
    logic storage_clock;
    logic shift_clear_n;
    logic storage_clear_n;
  } siplat_ctrl_s;

endpackage

// file: rtl/siplat_top.sv
// Purpose: Serial-in shifter with storage register and chain output.
// Assumes: Host pins synchronous to core_clk; edges found by sampling.
// Notes: Clears also mask outputs at once, ahead of the register update.
//   Edge history starts high, so a clock high at release is no edge.
`timescale 1ns/10ps
`include "siplat_regs.svh"

module siplat_top #(
  parameter int WIDTH = `SIPLAT_WIDTH
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire siplat_pkg::siplat_ctrl_s ctrl,
  output logic [WIDTH-1:0] parallel_out,
  output logic serial_chain_out
);

  logic [WIDTH-1:0] shift_q;
  logic [WIDTH-1:0] shift_d;
  logic [WIDTH-1:0] store_q;
  logic [WIDTH-1:0] store_d;
  logic shift_clk_q;
  logic store_clk_q;
  wire shift_rise;
  wire store_rise;
  wire sh_clr_n;
  wire st_clr_n;
  wire shift_take;
  wire store_take;

  // Edge detection on the two host clocks, kept independent
  assign shift_rise = ctrl.shift_clock & ~shift_clk_q;
  assign store_rise = ctrl.storage_clock & ~store_clk_q;
  assign sh_clr_n = ctrl.shift_clear_n;
  assign st_clr_n = ctrl.storage_clear_n;

  // Edges that the clears let through
  assign shift_take = shift_rise & sh_clr_n;
  assign store_take = store_rise & st_clr_n;

  // Next shifter value: clear, shift or hold
  assign shift_d = !sh_clr_n ? `SIPLAT_CLEAR_VAL :
                   shift_rise ? {shift_q[WIDTH-2:`SIPLAT_STAGE_IN],
                                 ctrl.serial_data_in} :
                   shift_q;

  // Next storage value: pre-edge shifter copy, so it trails by one
  assign store_d = !st_clr_n ? `SIPLAT_CLEAR_VAL :
                   store_rise ? shift_q :
                   store_q;

  // Outputs masked by the clears so they act without waiting
  assign parallel_out = st_clr_n ? store_q : `SIPLAT_CLEAR_VAL;
  assign serial_chain_out = sh_clr_n & shift_q[WIDTH-1];

  // Edge history
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      shift_clk_q <= `SIPLAT_EDGE_RST;
      store_clk_q <= `SIPLAT_EDGE_RST;
    end else begin
      shift_clk_q <= ctrl.shift_clock;
      store_clk_q <= ctrl.storage_clock;
    end
  end

  // Shifter and storage registers
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      shift_q <= `SIPLAT_CLEAR_VAL;
      store_q <= `SIPLAT_CLEAR_VAL;
    end else begin
      shift_q <= shift_d;
      store_q <= store_d;
    end
  end

  // Checks on shifting, transfer and clearing
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);

  sequence seq_shift;
    shift_rise && sh_clr_n;
  endsequence

  sequence seq_store;
    store_rise && st_clr_n;
  endsequence

  sequence seq_quiet_store;
    !store_rise && st_clr_n ##1 st_clr_n;
  endsequence

  AST_SHIFT_ADV: assert property (
    seq_shift |=> shift_q ==
      {$past(shift_q[WIDTH-2:0]), $past(ctrl.serial_data_in)})
    else $error("shifter did not advance on shift edge");

  AST_SHIFT_HOLD: assert property (
    !shift_rise && sh_clr_n |=> $stable(shift_q))
    else $error("shifter moved without a shift edge");

  AST_STORE_COPY: assert property (
    seq_store |=> store_q == $past(shift_q))
    else $error("storage did not copy the shifter");

  AST_OUT_STABLE: assert property (
    seq_quiet_store |-> $stable(parallel_out))
    else $error("parallel outputs changed without transfer");

  AST_COMMON_EDGE: assert property (
    seq_shift and seq_store |=>
      store_q == $past(shift_q) &&
      shift_q[WIDTH-1:1] == store_q[WIDTH-2:0])
    else $error("storage not one pulse behind shifter");

  AST_SHIFT_CLEAR: assert property (
    !sh_clr_n |-> !serial_chain_out ##1 shift_q == `SIPLAT_CLEAR_VAL)
    else $error("shift clear did not empty shifter");

  AST_STORE_CLEAR: assert property (
    !st_clr_n |-> parallel_out == `SIPLAT_CLEAR_VAL)
    else $error("storage clear did not act at once");

  AST_CLEAR_ISOLATE: assert property (
    !sh_clr_n && !store_rise && st_clr_n |=> $stable(store_q))
    else $error("shift clear disturbed storage");

  AST_CHAIN_OUT: assert property (
    seq_shift ##1 sh_clr_n |-> serial_chain_out == $past(shift_q[WIDTH-2]))
    else $error("chain output not last stage");

  // Clock edges that a low clear refuses
  sequence seq_shift_refused;
    shift_rise && !sh_clr_n;
  endsequence

  sequence seq_store_refused;
    store_rise && !st_clr_n;
  endsequence

  // A clear released after being held
  sequence seq_shift_release;
    !sh_clr_n ##1 sh_clr_n;
  endsequence

  sequence seq_store_release;
    !st_clr_n ##1 st_clr_n;
  endsequence

  // A host clock held high over two samples
  sequence seq_shift_held;
    ctrl.shift_clock ##1 ctrl.shift_clock;
  endsequence

  sequence seq_store_held;
    ctrl.storage_clock ##1 ctrl.storage_clock;
  endsequence

  // Refused edges and clear follow-through
  AST_SHIFT_REFUSE: assert property (
    seq_shift_refused |=> shift_q == `SIPLAT_CLEAR_VAL)
    else $error("shift edge taken while shift clear low");

  AST_STORE_REFUSE: assert property (
    seq_store_refused |=> store_q == `SIPLAT_CLEAR_VAL)
    else $error("transfer taken while storage clear low");

  AST_STORE_EMPTY: assert property (
    !st_clr_n |=> store_q == `SIPLAT_CLEAR_VAL)
    else $error("storage clear did not empty storage");

  AST_SHIFT_ISOLATE: assert property (
    !st_clr_n && !shift_rise && sh_clr_n |=> $stable(shift_q))
    else $error("storage clear disturbed shifter");

  AST_SHIFT_RELEASE: assert property (
    seq_shift_release |-> !serial_chain_out)
    else $error("chain output high just after shift clear");

  AST_STORE_RELEASE: assert property (
    seq_store_release |-> parallel_out == `SIPLAT_CLEAR_VAL)
    else $error("parallel outputs not empty after storage clear");

  // Outputs tracking their registers
  AST_STORE_HOLD: assert property (
    !store_rise && st_clr_n |=> $stable(store_q))
    else $error("storage moved without a transfer edge");

  AST_PAR_SHOWS: assert property (
    st_clr_n |-> parallel_out == store_q)
    else $error("parallel outputs differ from storage");

  AST_CHAIN_SHOWS: assert property (
    sh_clr_n |-> serial_chain_out == shift_q[WIDTH-1])
    else $error("chain output differs from last stage");

  AST_CHAIN_HOLD: assert property (
    !shift_rise && sh_clr_n ##1 sh_clr_n |-> $stable(serial_chain_out))
    else $error("chain output moved without a shift edge");

  // Edge detection and clock independence
  AST_SHIFT_ONCE: assert property (
    seq_shift_held |-> !shift_rise)
    else $error("held shift clock shifted twice");

  AST_STORE_ONCE: assert property (
    seq_store_held |-> !store_rise)
    else $error("held storage clock transferred twice");

  AST_STORE_INDEP: assert property (
    store_take && !shift_rise && sh_clr_n |=> $stable(shift_q))
    else $error("storage clock moved the shifter");

  AST_SHIFT_INDEP: assert property (
    shift_take && !store_rise && st_clr_n |=> $stable(store_q))
    else $error("shift clock moved the storage");

  AST_COMMON_CHAIN: assert property (
    (seq_shift and seq_store) ##1 sh_clr_n |->
      serial_chain_out == store_q[WIDTH-2])
    else $error("chain output not one stage past storage");

endmodule

// file: sim/siplat_host.sv
// Purpose: Host controller model driving the latch pins.
// Assumes: Pins change on the falling edge of core_clk.
// Notes: Clocks idle low; data inverts once its hold ends.
`timescale 1ns/10ps
module siplat_host (
  input wire logic core_clk,
  output siplat_pkg::siplat_ctrl_s ctrl
);
  // Idle pins: clocks low, clears released
  initial ctrl = 5'h03;
  // One rise on the chosen clocks, then back to idle low
  task automatic pulse(input logic d, input logic sh, input logic st);
    @(negedge core_clk);
    ctrl.serial_data_in = d;
    ctrl.shift_clock = 1'h0;
    ctrl.storage_clock = 1'h0;
    @(negedge core_clk);
    ctrl.shift_clock = sh;
    ctrl.storage_clock = st;
    @(negedge core_clk);
    ctrl.serial_data_in = ~d;
    ctrl.shift_clock = 1'h0;
    ctrl.storage_clock = 1'h0;
    @(negedge core_clk);
  endtask
  // Clear levels set off the edge and left standing
  task automatic clear(input logic sh_n, input logic st_n);
    @(negedge core_clk);
    ctrl.shift_clear_n = sh_n;
    ctrl.storage_clear_n = st_n;
    #1;
  endtask
endmodule

// file: sim/siplat_top_bench.sv
// Purpose: Self-checking bench for the serial-in latch.
// Assumes: Host model drives pins on the falling edge.
// Notes: Expected outputs come from a reference shifter.
`timescale 1ns/10ps
module siplat_top_bench;
  logic core_clk = 1'h0;
  logic rst_n = 1'h0;
  siplat_pkg::siplat_ctrl_s ctrl;
  logic [7:0] parallel_out;
  logic serial_chain_out;
  wire [8:0] seen_out = {parallel_out, serial_chain_out};
  logic [7:0] sh_m = 8'h00;
  logic [7:0] st_m = 8'h00;
  logic [8:0] exp_q[$];
  logic [31:0] lfsr = 32'h6aeb075f;
  int failures = 0;
  int n_tests = 0;
  event seen;
  // Clock
  always #5 core_clk = ~core_clk;
  siplat_top DUT (.core_clk(core_clk), .rst_n(rst_n), .ctrl(ctrl),
    .parallel_out(parallel_out), .serial_chain_out(serial_chain_out));
  siplat_host host (.core_clk(core_clk), .ctrl(ctrl));
  function automatic logic [31:0] next_rand(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  task automatic check(input logic [8:0] got, input logic [8:0] want);
    n_tests++;
    if (got !== want) begin
      failures++;
      $display("wrong value at %0t: %h expected %h", $time, got, want);
    end
  endtask
  task automatic summarize;
    if (failures == 0 && n_tests > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic note;
    exp_q.push_back({st_m, sh_m[7]});
    -> seen;
  endtask
  // Pulse clocks and advance the reference registers
  task automatic step(input logic d, input logic sh, input logic st);
    host.pulse(d, sh, st);
    if (st && ctrl.storage_clear_n) st_m = sh_m;
    if (sh && ctrl.shift_clear_n) sh_m = {sh_m[6:0], d};
    note;
  endtask
  // Clear levels: outputs looked at before the next edge, then held
  task automatic clr(input logic sh_n, input logic st_n);
    host.clear(sh_n, st_n);
    if (!sh_n) sh_m = 8'h00;
    if (!st_n) st_m = 8'h00;
    note;
    repeat (2) @(negedge core_clk);
    note;
  endtask
  // Watcher: oldest note against the outputs
  always @(seen) check(seen_out, exp_q.pop_front());
  // Main sequence
  initial begin
    repeat (4) @(posedge core_clk);
    @(negedge core_clk);
    rst_n = 1'h1;
    note;
    for (int b = 0; b < 3; b++) begin
      lfsr = next_rand(lfsr);
      for (int i = 7; i >= 0; i--) begin
        step(lfsr[i], 1'h1, 1'h0);
      end
      step(1'h0, 1'h0, 1'h1);
    end
    step(lfsr[8], 1'h1, 1'h0);
    step(lfsr[9], 1'h1, 1'h1);
    clr(1'h0, 1'h1);
    step(1'h1, 1'h1, 1'h0);
    clr(1'h1, 1'h1);
    step(1'h1, 1'h1, 1'h0);
    clr(1'h1, 1'h0);
    step(1'h1, 1'h1, 1'h1);
    clr(1'h1, 1'h1);
    step(1'h0, 1'h0, 1'h1);
    summarize;
  end
endmodule
